// file: hdl/hcl_aux_adc_ctrl.sv
`timescale 1ns/10ps
`include "hcl_defs.svh"
// How it works
// - a multiplexer sends battery, temperature or an auxiliary input to one converter
// - control register sets channel, scan, averaging, resolution and rate; results per source
// - resolution 8, 10 or 12 bits; fewer bits take fewer clocks
// - internal 8 MHz clock runs only while the oscillator is selected, divided by a control ratio
// - sampling uses internal clock cycles before the conversion clock cycles
// - with both audio converters down, clock comes from the oscillator
// - any audio converter up: oscillator off, clock from master or bit clock
// - pll on: mclk*K*13/(P*160), or mclk*K*17/(P*192) with ratio select
// - pll off: mclk*13/(Q*10), or mclk*17/(Q*12) with ratio select
// - results are unsigned binary, readable by the host
// - reference selects 1.25 V or 2.5 V, or turns internal reference off
// - scan converts battery, aux1 and aux2 from one write
module hcl_aux_adc_ctrl (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_audio_adc_on,
  input  wire logic        i_audio_dac_on,
  input  wire logic        i_audio_mclk,
  input  wire logic        i_bclk,
  input  wire logic        i_comparator,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic [1:0]       o_mux_sel,
  output logic             o_sample,
  output logic [11:0]      o_dac_code,
  output logic             o_ref_hi,
  output logic             o_int_ref_en,
  output logic             o_osc_en
);
  // pin synchronisers: comparator, bclk, audio mclk, dac on, adc on
  logic [4:0] pin_in;
  logic [4:0] s1_q, s2_q, s3_q, lvl_q, lvl_prev_q;
  assign pin_in = {i_comparator, i_bclk, i_audio_mclk,
                   i_audio_dac_on, i_audio_adc_on};
  for (genvar g = 0; g < 5; g++) begin : g_sync
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        s1_q[g]       <= 1'b0;
        s2_q[g]       <= 1'b0;
        s3_q[g]       <= 1'b0;
        lvl_q[g]      <= 1'b0;
        lvl_prev_q[g] <= 1'b0;
      end else begin
        s1_q[g]       <= pin_in[g];
        s2_q[g]       <= s1_q[g];
        s3_q[g]       <= s2_q[g];
        lvl_prev_q[g] <= lvl_q[g];
        if (s2_q[g] == s3_q[g]) begin
          lvl_q[g] <= s3_q[g];
        end
      end
    end
  end

  logic ext_req, mclk_rise, bclk_rise;
  assign ext_req   = lvl_q[0] | lvl_q[1];
  assign mclk_rise = lvl_q[2] & ~lvl_prev_q[2];
  assign bclk_rise = lvl_q[3] & ~lvl_prev_q[3];

  // registers
  logic [15:0] ctrl_q, clk_q;
  logic [1:0]  ref_q;
  logic [11:0] res_q [4];
  logic        done_q;

  // AXI4-Lite write path: address and data latched independently
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_full_q, w_full_q;
  logic        aw_hs, w_hs, do_wr, aw_full_d, w_full_d;
  logic [31:0] wmask;
  assign aw_hs     = i_s_axi_awvalid & o_s_axi_awready;
  assign w_hs      = i_s_axi_wvalid & o_s_axi_wready;
  assign do_wr     = aw_full_q & w_full_q & ~o_s_axi_bvalid;
  assign aw_full_d = (aw_full_q | aw_hs) & ~do_wr;
  assign w_full_d  = (w_full_q | w_hs) & ~do_wr;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{w_strb_q[b]}};
  end

  logic wr_ctrl, wr_ref, wr_clk, wr_hit, start_req;
  logic [15:0] ctrl_d, clk_d;
  logic [1:0]  ref_d;
  assign wr_ctrl = do_wr & (aw_addr_q == `HCL_OFF_CTRL);
  assign wr_ref  = do_wr & (aw_addr_q == `HCL_OFF_REF);
  assign wr_clk  = do_wr & (aw_addr_q == `HCL_OFF_CLK);
  assign wr_hit  = (aw_addr_q == `HCL_OFF_CTRL) |
                   (aw_addr_q == `HCL_OFF_REF) |
                   (aw_addr_q == `HCL_OFF_CLK);
  assign ctrl_d  = (ctrl_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
  assign clk_d   = (clk_q & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
  assign ref_d   = (ref_q & ~wmask[1:0]) | (w_data_q[1:0] & wmask[1:0]);
  // start is a strobe; the stored copy of the bit always reads zero
  assign start_req = wr_ctrl & w_strb_q[1] & w_data_q[`HCL_CTRL_START];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      aw_full_q      <= 1'b0;
      w_full_q       <= 1'b0;
      aw_addr_q      <= 8'h00;
      w_data_q       <= 32'h0000_0000;
      w_strb_q       <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `HCL_RESP_OKAY;
      ctrl_q         <= `HCL_CTRL_RST;
      clk_q          <= `HCL_CLK_RST;
      ref_q          <= `HCL_REF_RST;
    end else begin
      aw_full_q       <= aw_full_d;
      w_full_q        <= w_full_d;
      o_s_axi_awready <= ~aw_full_d;
      o_s_axi_wready  <= ~w_full_d;
      if (aw_hs) aw_addr_q <= {i_s_axi_awaddr[7:2], 2'h0};
      if (w_hs) begin
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end
      if (do_wr) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_hit ? `HCL_RESP_OKAY : `HCL_RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) ctrl_q <= {1'b0, ctrl_d[14:0]};
      if (wr_clk) clk_q <= clk_d;
      if (wr_ref) ref_q <= ref_d;
    end
  end

  // clock source selection and derived ticks
  hcl_pkg::hcl_top_state_e state_q;
  logic src_ext_q, src_ext_d, src_switch, seq_busy;
  assign src_ext_d  = (state_q == hcl_pkg::HCL_TP_IDLE && !seq_busy) ?
                      ext_req : src_ext_q;
  assign src_switch = src_ext_d != src_ext_q;

  logic [3:0]  k_f;
  logic [2:0]  p_f;
  logic [4:0]  q_f;
  logic        rsel, pll_on;
  logic [7:0]  ext_num;
  logic [10:0] ext_den, den_pll, den_q;
  assign k_f     = clk_q[`HCL_CLK_K];
  assign p_f     = clk_q[`HCL_CLK_P];
  assign q_f     = clk_q[`HCL_CLK_Q];
  assign rsel    = clk_q[`HCL_CLK_RSEL];
  assign pll_on  = clk_q[`HCL_CLK_PLL];
  assign den_pll = {8'h00, p_f} *
                   {3'h0, rsel ? `HCL_DEN_PLL_R1 : `HCL_DEN_PLL_R0};
  assign den_q   = {6'h00, q_f} *
                   {7'h00, rsel ? `HCL_DEN_Q_R1 : `HCL_DEN_Q_R0};
  assign ext_num = pll_on ? ({4'h0, k_f} *
                   (rsel ? `HCL_NUM_R1 : `HCL_NUM_R0)) :
                   (rsel ? `HCL_NUM_R1 : `HCL_NUM_R0);
  assign ext_den = pll_on ? den_pll : den_q;

  logic osc_tick, ext_tick, int_tick, conv_tick, ext_step;
  logic [2:0] div_q, div_max;
  assign ext_step = src_ext_q & (clk_q[`HCL_CLK_BCLK] ? bclk_rise
                                                      : mclk_rise);
  assign int_tick = src_ext_q ? ext_tick : osc_tick;
  assign div_max  = 3'((4'h1 << ctrl_q[`HCL_CTRL_DIV]) - 4'h1);
  assign conv_tick = int_tick & (div_q == div_max);

  hcl_tick_gen u_osc_tick (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_clear(src_switch),
    .i_step (o_osc_en),
    .i_num  (`HCL_OSC_NUM),
    .i_den  (`HCL_OSC_DEN),
    .o_tick (osc_tick)
  );
  hcl_tick_gen u_ext_tick (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_clear(src_switch),
    .i_step (ext_step),
    .i_num  (ext_num),
    .i_den  (ext_den),
    .o_tick (ext_tick)
  );

  // conversion sequencing: averaging and scan
  logic        seq_start_q, seq_done;
  // read handshake decode is declared here because the sticky done flag
  // above the read path clears on a status read
  logic        ar_hs, rd_stat;
  logic [11:0] seq_result;
  logic [2:0]  avg_cnt_q;
  logic [14:0] sum_q, sum_d;
  logic [1:0]  avg_sh;
  logic        last_avg, scan_more;
  assign avg_sh    = ctrl_q[`HCL_CTRL_AVG];
  assign sum_d     = sum_q + {3'h0, seq_result};
  assign last_avg  = avg_cnt_q == 3'((4'h1 << avg_sh) - 4'h1);
  assign scan_more = ctrl_q[`HCL_CTRL_SCAN] &&
                     o_mux_sel != hcl_pkg::HCL_CH_AUX2;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q     <= hcl_pkg::HCL_TP_IDLE;
      src_ext_q   <= 1'b0;
      o_osc_en    <= 1'b1;
      div_q       <= 3'h0;
      seq_start_q <= 1'b0;
      avg_cnt_q   <= 3'h0;
      sum_q       <= 15'h0000;
      o_mux_sel   <= hcl_pkg::HCL_CH_BAT;
      done_q      <= 1'b0;
      for (int i = 0; i < 4; i++) res_q[i] <= 12'h000;
    end else begin
      src_ext_q   <= src_ext_d;
      o_osc_en    <= ~src_ext_d;
      seq_start_q <= 1'b0;
      if (src_switch) div_q <= 3'h0;
      else if (int_tick) div_q <= (div_q == div_max) ? 3'h0 : div_q + 3'h1;
      if (rd_stat) done_q <= 1'b0;
      unique case (state_q)
        hcl_pkg::HCL_TP_IDLE: begin
          if (start_req) begin
            state_q   <= hcl_pkg::HCL_TP_LAUNCH;
            avg_cnt_q <= 3'h0;
            sum_q     <= 15'h0000;
            o_mux_sel <= ctrl_d[`HCL_CTRL_SCAN] ? hcl_pkg::HCL_CH_BAT
                                                : ctrl_d[`HCL_CTRL_CHAN];
          end
        end
        hcl_pkg::HCL_TP_LAUNCH: begin
          seq_start_q <= 1'b1;
          state_q     <= hcl_pkg::HCL_TP_WAIT;
        end
        hcl_pkg::HCL_TP_WAIT: begin
          if (seq_done) begin
            state_q   <= hcl_pkg::HCL_TP_LAUNCH;
            avg_cnt_q <= avg_cnt_q + 3'h1;
            sum_q     <= sum_d;
            if (last_avg) begin
              res_q[o_mux_sel] <= 12'(sum_d >> avg_sh);
              avg_cnt_q        <= 3'h0;
              sum_q            <= 15'h0000;
              if (scan_more) begin
                o_mux_sel <= (o_mux_sel == hcl_pkg::HCL_CH_BAT) ?
                             hcl_pkg::HCL_CH_AUX1 : hcl_pkg::HCL_CH_AUX2;
              end else begin
                state_q <= hcl_pkg::HCL_TP_IDLE;
                done_q  <= 1'b1;
              end
            end
          end
        end
        default: state_q <= hcl_pkg::HCL_TP_IDLE;
      endcase
    end
  end

  hcl_sar_seq u_seq (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_start    (seq_start_q),
    .i_res      (ctrl_q[`HCL_CTRL_RES]),
    .i_int_tick (int_tick),
    .i_conv_tick(conv_tick),
    .i_cmp      (lvl_q[4]),
    .o_busy     (seq_busy),
    .o_sample   (o_sample),
    .o_dac_code (o_dac_code),
    .o_done     (seq_done),
    .o_result   (seq_result)
  );

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ref_hi     <= 1'b0;
      o_int_ref_en <= 1'b1;
    end else begin
      o_ref_hi     <= ref_q[`HCL_REF_HI];
      o_int_ref_en <= ~ref_q[`HCL_REF_OFF];
    end
  end

  // AXI4-Lite read path: one cycle from address to data
  logic [31:0] rd_data;
  logic [3:0]  stat_v;
  assign ar_hs   = i_s_axi_arvalid & o_s_axi_arready;
  assign rd_stat = ar_hs && i_s_axi_araddr[7:2] == `HCL_OFF_STAT >> 2;
  assign stat_v  = {done_q, o_osc_en, src_ext_q,
                    state_q != hcl_pkg::HCL_TP_IDLE};
  always_comb begin
    unique case ({i_s_axi_araddr[7:2], 2'h0})
      `HCL_OFF_CTRL:     rd_data = {16'h0000, ctrl_q};
      `HCL_OFF_REF:      rd_data = {30'h0, ref_q};
      `HCL_OFF_CLK:      rd_data = {16'h0000, clk_q};
      `HCL_OFF_STAT:     rd_data = {28'h0, stat_v};
      `HCL_OFF_RES_BAT:  rd_data = {20'h0, res_q[0]};
      `HCL_OFF_RES_TEMP: rd_data = {20'h0, res_q[1]};
      `HCL_OFF_RES_AUX1: rd_data = {20'h0, res_q[2]};
      `HCL_OFF_RES_AUX2: rd_data = {20'h0, res_q[3]};
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= `HCL_RESP_OKAY;
    end else if (ar_hs) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rdata   <= rd_data;
      o_s_axi_rresp   <= (i_s_axi_araddr[7:2] > 6'h07) ?
                         `HCL_RESP_SLVERR : `HCL_RESP_OKAY;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_ext_source_on: assert property (
    (state_q == hcl_pkg::HCL_TP_IDLE && !seq_busy && ext_req) [*2]
    |-> src_ext_q && !o_osc_en)
    else $error("audio active but oscillator still clocks converter");
  a_osc_source_on: assert property (
    (state_q == hcl_pkg::HCL_TP_IDLE && !seq_busy && !ext_req) [*2]
    |-> !src_ext_q && o_osc_en)
    else $error("audio down but oscillator not selected");
  a_src_held_busy: assert property (
    seq_busy && $past(seq_busy) |-> $stable(src_ext_q))
    else $error("clock source changed during a conversion");
  a_div_tick_src: assert property (
    conv_tick |-> int_tick)
    else $error("conversion tick without internal tick");
  a_scan_step: assert property (
    seq_done && last_avg && scan_more &&
    o_mux_sel == hcl_pkg::HCL_CH_BAT |=> o_mux_sel == hcl_pkg::HCL_CH_AUX1)
    else $error("scan did not advance from battery to aux1");
  a_start_launch: assert property (
    start_req && state_q == hcl_pkg::HCL_TP_IDLE |=> ##1 seq_start_q)
    else $error("start write did not launch a conversion");
  a_bvalid_hold: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped before bready");

  c_scan_done: cover property (
    ctrl_q[`HCL_CTRL_SCAN] && $rose(done_q));
  c_ext_conv: cover property (src_ext_q && seq_done);
  c_avg_conv: cover property (avg_sh != 2'h0 && seq_done && last_avg);
endmodule

// file: hdl/hcl_defs.svh
`ifndef HCL_DEFS_SVH
`define HCL_DEFS_SVH

// clock rates
`define HCL_CLK_HZ        250000000
`define HCL_OSC_HZ        8000000
// oscillator tick ratio: 8 MHz out of 250 MHz, reduced fraction
`define HCL_OSC_NUM       8'h04
`define HCL_OSC_DEN       11'h07D
// sampling phase length, in internal clock ticks
`define HCL_SAMPLE_TICKS  3
// derived clock ratio factors
`define HCL_NUM_R0        8'h0D
`define HCL_NUM_R1        8'h11
`define HCL_DEN_PLL_R0    8'hA0
`define HCL_DEN_PLL_R1    8'hC0
`define HCL_DEN_Q_R0      4'hA
`define HCL_DEN_Q_R1      4'hC

// register byte offsets
`define HCL_OFF_CTRL      8'h00
`define HCL_OFF_REF       8'h04
`define HCL_OFF_CLK       8'h08
`define HCL_OFF_STAT      8'h0C
`define HCL_OFF_RES_BAT   8'h10
`define HCL_OFF_RES_TEMP  8'h14
`define HCL_OFF_RES_AUX1  8'h18
`define HCL_OFF_RES_AUX2  8'h1C

// control register fields
`define HCL_CTRL_CHAN     1:0
`define HCL_CTRL_SCAN     2
`define HCL_CTRL_AVG      4:3
`define HCL_CTRL_RES      6:5
`define HCL_CTRL_DIV      8:7
`define HCL_CTRL_START    15
`define HCL_CTRL_RST      16'h0000
// reference register fields
`define HCL_REF_HI        0
`define HCL_REF_OFF       1
`define HCL_REF_RST       2'h0
// clock register fields
`define HCL_CLK_RSEL      0
`define HCL_CLK_PLL       1
`define HCL_CLK_BCLK      2
`define HCL_CLK_K         7:4
`define HCL_CLK_P         10:8
`define HCL_CLK_Q         15:11
`define HCL_CLK_RST       16'h0910
// status bits
`define HCL_ST_BUSY       0
`define HCL_ST_EXT        1
`define HCL_ST_OSC        2
`define HCL_ST_DONE       3

`define HCL_RESP_OKAY     2'h0
`define HCL_RESP_SLVERR   2'h2

`endif

// file: hdl/hcl_pkg.sv
package hcl_pkg;
  typedef enum logic [1:0] {
    HCL_CH_BAT, HCL_CH_TEMP, HCL_CH_AUX1, HCL_CH_AUX2
  } hcl_chan_e;
  typedef enum logic [1:0] {
    HCL_RES_12, HCL_RES_10, HCL_RES_8
  } hcl_res_e;
  typedef enum logic [1:0] {
    HCL_SQ_IDLE, HCL_SQ_SAMPLE, HCL_SQ_CONV
  } hcl_seq_state_e;
  typedef enum logic [1:0] {
    HCL_TP_IDLE, HCL_TP_LAUNCH, HCL_TP_WAIT
  } hcl_top_state_e;
endpackage

// file: hdl/hcl_tick_gen.sv
`timescale 1ns/10ps
// fractional rate generator: i_num ticks per i_den steps
module hcl_tick_gen #(
  parameter int NW = 8,
  parameter int DW = 11
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  input  wire logic          i_clear,
  input  wire logic          i_step,
  input  wire logic [NW-1:0] i_num,
  input  wire logic [DW-1:0] i_den,
  output logic               o_tick
);
  logic [DW:0] acc_q;
  logic [DW:0] sum;
  logic [DW:0] rem;
  logic        hit;

  assign sum = acc_q + {{(DW+1-NW){1'b0}}, i_num};
  assign rem = sum - {1'b0, i_den};
  assign hit = sum >= {1'b0, i_den};

  always_ff @(posedge i_mclk) begin
    if (i_rst || i_clear) begin
      acc_q  <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_step & hit;
      if (i_step) begin
        // ratios above one saturate at one tick per step
        acc_q <= hit ? ((rem >= {1'b0, i_den}) ? '0 : rem) : sum;
      end
    end
  end
endmodule

// file: hdl/hcl_sar_seq.sv
`timescale 1ns/10ps
`include "hcl_defs.svh"
// one conversion: sample on internal ticks, then one bit per conv tick
module hcl_sar_seq #(
  parameter int SAMPLE_TICKS = `HCL_SAMPLE_TICKS
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic [1:0]  i_res,
  input  wire logic        i_int_tick,
  input  wire logic        i_conv_tick,
  input  wire logic        i_cmp,
  output logic             o_busy,
  output logic             o_sample,
  output logic [11:0]      o_dac_code,
  output logic             o_done,
  output logic [11:0]      o_result
);
  hcl_pkg::hcl_seq_state_e state_q;
  logic [3:0]  bit_q;
  logic [3:0]  lsb;
  logic [3:0]  samp_q;
  logic [11:0] kept;

  assign lsb  = (i_res == hcl_pkg::HCL_RES_12) ? 4'h0 :
                (i_res == hcl_pkg::HCL_RES_10) ? 4'h2 : 4'h4;
  assign kept = i_cmp ? o_dac_code : (o_dac_code & ~(12'h001 << bit_q));

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q    <= hcl_pkg::HCL_SQ_IDLE;
      bit_q      <= 4'h0;
      samp_q     <= 4'h0;
      o_busy     <= 1'b0;
      o_sample   <= 1'b0;
      o_dac_code <= 12'h000;
      o_done     <= 1'b0;
      o_result   <= 12'h000;
    end else begin
      o_done <= 1'b0;
      unique case (state_q)
        hcl_pkg::HCL_SQ_IDLE: begin
          if (i_start) begin
            state_q  <= hcl_pkg::HCL_SQ_SAMPLE;
            samp_q   <= 4'h0;
            o_busy   <= 1'b1;
            o_sample <= 1'b1;
          end
        end
        hcl_pkg::HCL_SQ_SAMPLE: begin
          if (i_int_tick) begin
            samp_q <= samp_q + 4'h1;
            if (samp_q == 4'(SAMPLE_TICKS - 1)) begin
              state_q    <= hcl_pkg::HCL_SQ_CONV;
              o_sample   <= 1'b0;
              bit_q      <= 4'hB;
              o_dac_code <= 12'h800;
            end
          end
        end
        hcl_pkg::HCL_SQ_CONV: begin
          if (i_conv_tick) begin
            if (bit_q == lsb) begin
              state_q  <= hcl_pkg::HCL_SQ_IDLE;
              o_busy   <= 1'b0;
              o_done   <= 1'b1;
              o_result <= kept >> lsb;
            end else begin
              bit_q      <= bit_q - 4'h1;
              o_dac_code <= kept | (12'h001 << (bit_q - 4'h1));
            end
          end
        end
        default: state_q <= hcl_pkg::HCL_SQ_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_sample_length: assert property (
    $fell(o_sample) |-> samp_q == 4'(SAMPLE_TICKS))
    else $error("sampling phase ended at wrong tick count");
  a_result_width: assert property (
    o_done && i_res == hcl_pkg::HCL_RES_8 |-> o_result[11:8] == 4'h0)
    else $error("8-bit result has upper bits set");
  a_done_pulse: assert property (
    o_done |=> !o_done && !o_busy)
    else $error("done is not a single pulse");
endmodule

// file: test/hcl_afe_model.sv
`timescale 1ns/10ps
// analog front end: per-source input level, ideal comparator, audio clocks
module hcl_afe_model (
  input  wire logic        i_mclk,
  input  wire logic        i_clk_run,
  input  wire logic [47:0] i_vin,
  input  wire logic [1:0]  i_mux_sel,
  input  wire logic [11:0] i_dac_code,
  output logic             o_cmp,
  output logic             o_amclk,
  output logic             o_bclk
);
  logic [11:0] vin_sel;
  logic [3:0]  cnt_q = 4'h0;
  logic        am_q  = 1'b0;
  logic        bc_q  = 1'b0;
  assign vin_sel = i_vin[i_mux_sel*12 +: 12];
  // no offset, so an ideal search lands exactly on the input level
  assign o_cmp = (vin_sel >= i_dac_code);
  assign o_amclk = am_q;
  assign o_bclk = bc_q;
  // audio clocks stand still while no audio converter is powered
  always @(posedge i_mclk) begin
    if (!i_clk_run) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h4 || cnt_q == 4'h9) begin
        am_q <= ~am_q;
      end
      if (cnt_q == 4'h9) begin
        bc_q <= ~bc_q;
      end
    end
  end
endmodule

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        clk = 1'b0, rst = 1'b1, dac_on = 1'b0;
  logic        cmp, amclk, bclk, awr, wr_y, bv, arr, rv, mux_x;
  logic        smp, rhi, ren, osc;
  logic [1:0]  mux, br, rr;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, x;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [11:0] dac;
  logic [47:0] vin = {12'h800, 12'h7FF, 12'h3E1, 12'hA5C};
  int          err_total = 0, total_checks = 0;
  always #2 clk = ~clk;
  hcl_afe_model i_afe (.i_mclk(clk), .i_clk_run(dac_on), .i_vin(vin),
    .i_mux_sel(mux), .i_dac_code(dac), .o_cmp(cmp), .o_amclk(amclk),
    .o_bclk(bclk));
  hcl_aux_adc_ctrl i_dut (.i_mclk(clk), .i_rst(rst), .i_audio_adc_on(1'b0),
    .i_audio_dac_on(dac_on), .i_audio_mclk(amclk), .i_bclk(bclk),
    .i_comparator(cmp), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_y), .o_s_axi_bresp(br),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .i_s_axi_araddr(ara),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd),
    .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .o_mux_sel(mux), .o_sample(smp), .o_dac_code(dac), .o_ref_hi(rhi),
    .o_int_ref_en(ren), .o_osc_en(osc));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // ready is registered, so its value at the falling edge is what the
  // next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, sa, sw;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    ta = 1'b0; tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge clk);
      sa = awr && !ta; sw = wr_y && !tw;
      @(posedge clk);
      if (sa) begin awv <= 1'b0; ta = 1'b1; end
      if (sw) begin wv <= 1'b0; tw = 1'b1; end
    end
    do @(negedge clk); while (!bv);
    chk({30'h0, br}, {30'h0, er});
    @(posedge clk);
    bry <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     input logic [1:0] er);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    d = rd;
    chk({30'h0, rr}, {30'h0, er});
    @(posedge clk);
    rry <= 1'b0;
  endtask
  task automatic wait_done;
    do rdr(8'h0C, x, 2'h0); while (!x[3]);
  endtask
  task automatic t_reset;
    rdr(8'h00, x, 2'h0); chk(x, 32'h0);
    rdr(8'h08, x, 2'h0); chk(x, 32'h0910);
    rdr(8'h0C, x, 2'h0); chk(x[2:0], 3'h4);
    rdr(8'h20, x, 2'h2); chk(x, 32'h0);
    wr(8'h10, 32'h5, 2'h2);
    rdr(8'h10, x, 2'h0); chk(x, 32'h0);
  endtask
  // each source at each resolution; the divider follows the resolution
  task automatic t_single;
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 4; c++) begin
        wr(8'h00, 32'h8000 | (r == 0 ? 32'h80 : 0) | (r << 5) | c, 2'h0);
        wait_done();
        rdr(8'h10 + 8'(c * 4), x, 2'h0);
        chk(x, 32'(vin[c*12 +: 12] >> (2 * r)));
      end
    end
  endtask
  task automatic t_scan;
    vin <= {12'h001, 12'hFFF, 12'h3E1, 12'h123};
    wr(8'h00, 32'h8084, 2'h0);
    wait_done();
    rdr(8'h10, x, 2'h0); chk(x, 32'h123);
    rdr(8'h18, x, 2'h0); chk(x, 32'hFFF);
    rdr(8'h1C, x, 2'h0); chk(x, 32'h001);
    chk({30'h0, mux}, 32'h3);
    rdr(8'h14, x, 2'h0); chk(x, 32'h03E);
  endtask
  task automatic t_ref;
    for (int v = 0; v < 4; v++) begin
      wr(8'h04, 32'(v), 2'h0);
      rdr(8'h04, x, 2'h0); chk(x, 32'(v));
      chk({30'h0, rhi, ren}, {30'h0, v[0], ~v[1]});
    end
  endtask
  task automatic t_ext;
    dac_on <= 1'b1;
    repeat (12) @(posedge clk);
    chk({31'h0, osc}, 32'h0);
    rdr(8'h0C, x, 2'h0); chk(x[2:1], 2'h1);
    wr(8'h00, 32'h80AA, 2'h0);
    wait_done();
    rdr(8'h18, x, 2'h0); chk(x, 32'h3FF);
    dac_on <= 1'b0;
    repeat (12) @(posedge clk);
    chk({31'h0, osc}, 32'h1);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_scan();
    t_ref();
    t_ext();
    results();
  end
  initial begin
    #300000;
    err_total++;
    results();
  end
endmodule
